// ==== include/ssp_pkg.sv ====
package ssp_pkg;
	localparam int ADDR_W = 8;
	localparam int RDATA_W = 32;
	// Byte addresses, one aligned word each
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TXBUF = 8'h04;
	localparam logic [7:0] OFF_RXBUF = 8'h08;
	localparam logic [7:0] OFF_FLAGS = 8'h0C;
	localparam logic [7:0] OFF_MASK = 8'h10;
	// Field positions of the control word
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_POL_BIT = 1;
	localparam int CTRL_PHA_BIT = 2;
	localparam int CTRL_DIV_LSB = 8;
	localparam int CTRL_W = 16;
	// Field positions of flags and mask
	localparam int FLG_BUSY_BIT = 0;
	localparam int FLG_TX_BIT = 1;
	localparam int FLG_RX_BIT = 2;
	localparam int FLG_FULL_BIT = 3;
	localparam int FLG_W = 4;
	// Reset values
	localparam logic [7:0] BAUD_DIV_RESET = 8'h04;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// Half-bit period is (baud_div + 1) core clock cycles
	localparam int CORE_CLK_MHZ = 100;

	typedef struct packed {
		logic [7:0] baud_div;
		logic [4:0] rsvd;
		logic clock_phase_sel;
		logic clock_polarity_sel;
		logic enable;
	} ssp_ctrl_t;

	typedef struct packed {
		logic buf_full;
		logic rx_req_flag;
		logic tx_req_flag;
		logic xfer_active_flag;
	} ssp_flags_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SHIFT,
		ST_TAIL
	} ssp_state_t;
endpackage

// ==== test/ssp_master_assertions.sv ====
`timescale 1ns/100ps
module ssp_master_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [ssp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ssp_pkg::RDATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic pxfer_wr,
	input wire logic pxfer_count_zero,
	input wire logic spi_sclk,
	input wire logic spi_sel_n,
	input wire logic irq
);
	// Half bit at the reset baud divider; the bench keeps that rate
	localparam int HB = 5;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic en, pol, mtx, mrx, ld, txw, idle;
	assign txw = reg_wr && reg_addr == ssp_pkg::OFF_TXBUF;
	assign idle = en && spi_sel_n && !ld;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			{en, pol, mtx, mrx, ld} <= '0;
		end else begin
			if (reg_wr && reg_addr == ssp_pkg::OFF_CTRL) {pol, en} <= reg_wdata[1:0];
			if (reg_wr && reg_addr == ssp_pkg::OFF_MASK) {mrx, mtx} <= reg_wdata[2:1];
			// Loaded but not yet started: the shifter is not empty
			ld <= en && (txw || pxfer_wr || ld && spi_sel_n);
		end
	end
	// Select is registered off the tick, so it shows one cycle after the tick
	a_busy_late: assert property (txw && idle |=> ##[1:HB] !spi_sel_n)
		else $error("busy start late");
	a_busy_park: assert property ($rose(spi_sel_n) |-> spi_sclk == pol)
		else $error("busy end off edge");
	a_frame_pol: assert property ($fell(spi_sel_n) |-> spi_sclk == pol)
		else $error("frame start level");
	a_edge_gap: assert property ($changed(spi_sclk) && !spi_sel_n |=> $stable(spi_sclk) [*4])
		else $error("clock edge spacing");
	a_txreq_now: assert property (mtx && (txw || pxfer_wr) && idle |=> irq)
		else $error("tx request late");
	a_txreq_late: assert property (mtx && !mrx && txw && !spi_sel_n && !irq && !pxfer_count_zero
		&& !$past(reg_wr) |=> !irq || $changed(spi_sclk)) else $error("tx request early");
	a_rx_done: assert property (mrx && !mtx && $rose(irq) && !$past(reg_wr)
		&& !$past(reg_wr, 2) |-> $changed(spi_sclk)) else $error("rx request off edge");
	a_cz_req: assert property (mtx && pxfer_count_zero |=> irq)
		else $error("count zero lost");
	c_done: cover property ($rose(spi_sel_n));
	c_b2b: cover property (txw && !spi_sel_n);
	c_cz: cover property (pxfer_count_zero && pxfer_wr);
endmodule
bind ssp_master ssp_master_chk chk (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .pxfer_wr(pxfer_wr),
	.pxfer_count_zero(pxfer_count_zero), .spi_sclk(spi_sclk), .spi_sel_n(spi_sel_n), .irq(irq));

// ==== test/ssp_slave_model.sv ====
`timescale 1ns/100ps
module ssp_slave_model (
	input wire logic core_clk,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	input wire logic spi_sel_n,
	output logic spi_miso,
	output logic [7:0] got
);
	logic [7:0] sr = 8'hA5;
	logic prev = 1'b0;
	logic junk = 1'b0;
	logic seen = 1'b0;
	// Deselected line toggles, so a stale bit never looks valid
	assign spi_miso = spi_sel_n ? junk : sr[7];
	always @(posedge core_clk) begin
		prev <= spi_sclk;
		junk <= ~junk;
		if (spi_sel_n) begin
			sr <= 8'hA5;
			seen <= 1'b0;
		end else if (spi_sclk && !prev) begin
			got <= {got[6:0], spi_mosi};
			seen <= 1'b1;
		end else if (!spi_sclk && prev && seen) begin
			// Polarity-1 frames open on a falling edge that must not shift
			sr <= {sr[6:0], 1'b0};
		end
	end
endmodule

// ==== test/tb_ssp_master.sv ====
`timescale 1ns/100ps
module tb_ssp_master;
	logic core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic pxfer_wr = 1'b0, pxfer_count_zero = 1'b0;
	logic [7:0] reg_addr = '0, pxfer_data = '0, got;
	logic [31:0] reg_wdata = '0, reg_rdata, rdv;
	logic spi_miso, spi_sclk, spi_mosi, spi_sel_n, irq;
	int errors = 0, check_count = 0, cyc = 0;
	always #5 core_clk = ~core_clk;
	ssp_master uut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pxfer_wr(pxfer_wr), .pxfer_data(pxfer_data), .pxfer_count_zero(pxfer_count_zero),
		.spi_miso(spi_miso), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_sel_n(spi_sel_n), .irq(irq));
	ssp_slave_model slave (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_sel_n(spi_sel_n), .spi_miso(spi_miso), .got(got));
	task wrap_up;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		cmp(nm, e, reg_rdata);
	endtask
	task wait_sel(input logic v);
		int n;
		n = 0;
		while (spi_sel_n !== v && n < 300) begin
			@(posedge core_clk);
			#1 n++;
		end
		cmp("sel_n", {31'h0, v}, {31'h0, spi_sel_n});
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(ssp_pkg::OFF_CTRL, 32'h00000400, "ctrl");
		rd(ssp_pkg::OFF_MASK, 32'h00000000, "mask");
		wr(8'h14, 32'hFFFFFFFF);
		rd(8'h14, 32'h00000000, "unmapped");
		wr(ssp_pkg::OFF_TXBUF, 32'h000000FF);
		repeat (12) @(posedge core_clk);
		cmp("sel_disabled", 32'h1, {31'h0, spi_sel_n});
		wr(ssp_pkg::OFF_CTRL, 32'h00000401);
		wr(ssp_pkg::OFF_MASK, 32'h00000004);
		wr(ssp_pkg::OFF_TXBUF, 32'h0000003C);
		wait_sel(1'b0);
		wait_sel(1'b1);
		cmp("irq_rx", 32'h1, {31'h0, irq});
		cmp("mosi", 32'h3C, {24'h0, got});
		rd(ssp_pkg::OFF_RXBUF, 32'h000000A5, "rxbuf");
		rd(ssp_pkg::OFF_FLAGS, 32'h00000006, "flags");
		@(posedge core_clk);
		#1;
		cmp("irq_clr", 32'h0, {31'h0, irq});
		wr(ssp_pkg::OFF_MASK, 32'h00000002);
		wr(ssp_pkg::OFF_TXBUF, 32'h00000081);
		wait_sel(1'b0);
		rd(ssp_pkg::OFF_FLAGS, 32'h00000003, "flags_busy");
		wr(ssp_pkg::OFF_TXBUF, 32'h00000042);
		rd(ssp_pkg::OFF_FLAGS, 32'h00000009, "flags_full");
		wait_sel(1'b1);
		cmp("mosi_b2b", 32'h42, {24'h0, got});
		rd(ssp_pkg::OFF_FLAGS, 32'h00000006, "flags_b2b");
		wr(ssp_pkg::OFF_MASK, 32'h00000006);
		pxfer_data <= 8'h5A;
		pxfer_wr <= 1'b1;
		pxfer_count_zero <= 1'b1;
		@(posedge core_clk);
		pxfer_wr <= 1'b0;
		pxfer_count_zero <= 1'b0;
		wait_sel(1'b0);
		rd(ssp_pkg::OFF_FLAGS, 32'h00000003, "flags_merged");
		rd(ssp_pkg::OFF_FLAGS, 32'h00000001, "flags_once");
		wait_sel(1'b1);
		cmp("mosi_event", 32'h5A, {24'h0, got});
		wr(ssp_pkg::OFF_CTRL, 32'h00000407);
		wr(ssp_pkg::OFF_TXBUF, 32'h000000C3);
		wait_sel(1'b0);
		wait_sel(1'b1);
		cmp("mosi_mode3", 32'hC3, {24'h0, got});
		rd(ssp_pkg::OFF_RXBUF, 32'h000000A5, "rxbuf_mode3");
		rd(ssp_pkg::OFF_FLAGS, 32'h00000006, "flags_mode3");
		wrap_up();
	end
endmodule

// ==== verilog/ssp_master.sv ====
`timescale 1ns/100ps
module ssp_master #(
	parameter int DATA_W = 8
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [ssp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ssp_pkg::RDATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ssp_pkg::RDATA_W-1:0] reg_rdata,
	input wire logic pxfer_wr,
	input wire logic [DATA_W-1:0] pxfer_data,
	input wire logic pxfer_count_zero,
	input wire logic spi_miso,
	output logic spi_sclk,
	output logic spi_mosi,
	output logic spi_sel_n,
	output logic irq
);
	localparam int EW = $clog2(2 * DATA_W);
	localparam logic [EW-1:0] LAST_EDGE = EW'(2 * DATA_W - 1);

	function automatic logic [EW-1:0] last_latch(input logic pha);
		last_latch = EW'(2 * DATA_W - 2) + EW'(pha);
	endfunction

	logic rst_meta;
	logic rst_n;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	ssp_pkg::ssp_ctrl_t ctrl, next_ctrl;
	ssp_pkg::ssp_flags_t flags, next_flags;
	localparam int FLG_W_C = ssp_pkg::FLG_W;
	ssp_pkg::ssp_state_t state, next_state;
	logic [FLG_W_C-1:0] mask, next_mask;
	logic [7:0] baud_cnt, next_baud_cnt;
	logic [EW-1:0] edge_cnt, next_edge_cnt;
	logic [DATA_W-1:0] tx_buf, next_tx_buf;
	logic [DATA_W-1:0] tx_shift, next_tx_shift;
	logic [DATA_W-1:0] rx_shift, next_rx_shift;
	logic [DATA_W-1:0] rx_data, next_rx_data;
	logic [ssp_pkg::RDATA_W-1:0] next_rdata;
	logic next_sclk, next_mosi, next_irq;
	logic tick;

	// Free-running generator: the first tick after a write lands anywhere
	// within one half-bit, so busy may lag the write by that much
	always_comb begin
		tick = ctrl.enable && (baud_cnt == 8'h00);
		if (!ctrl.enable || tick) begin
			next_baud_cnt = ctrl.baud_div;
		end else begin
			next_baud_cnt = baud_cnt - 8'h01;
		end
	end

	always_comb begin
		logic data_wr;
		logic [DATA_W-1:0] data_in;
		logic load_en;
		logic [DATA_W-1:0] load_val;
		logic set_tx;
		logic set_rx;
		logic flags_rd;
		logic pha;
		data_wr = 1'b0;
		data_in = '0;
		load_en = 1'b0;
		load_val = '0;
		set_tx = 1'b0;
		set_rx = 1'b0;
		flags_rd = reg_rd && (reg_addr == ssp_pkg::OFF_FLAGS);
		pha = ctrl.clock_phase_sel;
		next_ctrl = ctrl;
		next_mask = mask;
		next_flags = flags;
		next_state = state;
		next_edge_cnt = edge_cnt;
		next_tx_buf = tx_buf;
		next_tx_shift = tx_shift;
		next_rx_shift = rx_shift;
		next_rx_data = rx_data;
		next_sclk = spi_sclk;
		next_mosi = spi_mosi;

		if (reg_wr && reg_addr == ssp_pkg::OFF_CTRL) begin
			next_ctrl = ssp_pkg::ssp_ctrl_t'(reg_wdata[ssp_pkg::CTRL_W-1:0]);
			next_ctrl.rsvd = '0;
		end
		if (reg_wr && reg_addr == ssp_pkg::OFF_MASK) begin
			next_mask = reg_wdata[FLG_W_C-1:0];
		end
		// Bus write wins over an event-controller write in the same cycle
		if (reg_wr && reg_addr == ssp_pkg::OFF_TXBUF) begin
			data_wr = 1'b1;
			data_in = reg_wdata[DATA_W-1:0];
		end else if (pxfer_wr) begin
			data_wr = 1'b1;
			data_in = pxfer_data;
		end

		if (!ctrl.enable) begin
			// Disabled port drops writes and parks the clock
			next_state = ssp_pkg::ST_IDLE;
			next_flags.xfer_active_flag = 1'b0;
			next_flags.buf_full = 1'b0;
			next_sclk = ctrl.clock_polarity_sel;
		end else begin
			if (data_wr && state != ssp_pkg::ST_IDLE) begin
				next_tx_buf = data_in;
				next_flags.buf_full = 1'b1;
			end
			case (state)
				ssp_pkg::ST_IDLE: begin
					next_sclk = ctrl.clock_polarity_sel;
					if (data_wr) begin
						load_en = 1'b1;
						load_val = data_in;
						set_tx = 1'b1;
						next_state = ssp_pkg::ST_WAIT;
					end
				end
				ssp_pkg::ST_WAIT: begin
					if (tick) begin
						next_flags.xfer_active_flag = 1'b1;
						next_edge_cnt = '0;
						next_state = ssp_pkg::ST_SHIFT;
					end
				end
				ssp_pkg::ST_SHIFT: begin
					if (tick) begin
						next_sclk = ~spi_sclk;
						next_edge_cnt = (edge_cnt == LAST_EDGE) ? '0 : edge_cnt + EW'(1);
						if (edge_cnt[0] == pha) begin
							next_rx_shift = {rx_shift[DATA_W-2:0], spi_miso};
							if (edge_cnt == last_latch(pha)) begin
								next_rx_data = {rx_shift[DATA_W-2:0], spi_miso};
								set_rx = 1'b1;
								if (flags.buf_full) begin
									load_en = 1'b1;
									load_val = tx_buf;
									next_flags.buf_full = data_wr;
									set_tx = 1'b1;
								end else begin
									next_state = ssp_pkg::ST_TAIL;
								end
							end
						end else begin
							next_mosi = tx_shift[DATA_W-1];
							next_tx_shift = {tx_shift[DATA_W-2:0], 1'b0};
						end
					end
				end
				ssp_pkg::ST_TAIL: begin
					if (tick) begin
						next_sclk = ctrl.clock_polarity_sel;
						next_flags.xfer_active_flag = 1'b0;
						next_state = ssp_pkg::ST_IDLE;
						if (flags.buf_full) begin
							load_en = 1'b1;
							load_val = tx_buf;
							next_flags.buf_full = data_wr;
							set_tx = 1'b1;
							next_state = ssp_pkg::ST_WAIT;
						end else if (data_wr) begin
							load_en = 1'b1;
							load_val = data_in;
							next_flags.buf_full = 1'b0;
							set_tx = 1'b1;
							next_state = ssp_pkg::ST_WAIT;
						end
					end
				end
				default: begin
					next_state = ssp_pkg::ST_IDLE;
				end
			endcase
		end

		// Phase 0 from rest needs the first bit out before the first edge;
		// back to back, the trailing edge of the last bit shifts it out
		if (load_en) begin
			if (!pha && state != ssp_pkg::ST_SHIFT) begin
				next_mosi = load_val[DATA_W-1];
				next_tx_shift = {load_val[DATA_W-2:0], 1'b0};
			end else begin
				next_tx_shift = load_val;
			end
		end

		// Count-zero and buffer-empty share one sticky request, so two events
		// that arrive before the flag is read collapse into one
		set_tx = set_tx || pxfer_count_zero;
		// Read clears, but a new event in the same cycle survives
		next_flags.tx_req_flag = (flags.tx_req_flag && !flags_rd) || set_tx;
		next_flags.rx_req_flag = (flags.rx_req_flag && !flags_rd) || set_rx;

		next_irq = (next_flags.tx_req_flag && next_mask[ssp_pkg::FLG_TX_BIT])
			|| (next_flags.rx_req_flag && next_mask[ssp_pkg::FLG_RX_BIT]);

		next_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				ssp_pkg::OFF_CTRL: next_rdata = {16'h0000, ctrl};
				ssp_pkg::OFF_TXBUF: next_rdata[DATA_W-1:0] = tx_buf;
				ssp_pkg::OFF_RXBUF: next_rdata[DATA_W-1:0] = rx_data;
				ssp_pkg::OFF_FLAGS: next_rdata[FLG_W_C-1:0] = flags;
				ssp_pkg::OFF_MASK: next_rdata[FLG_W_C-1:0] = mask;
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '{baud_div: ssp_pkg::BAUD_DIV_RESET, default: 1'b0};
			mask <= ssp_pkg::MASK_RESET;
			flags <= '0;
			state <= ssp_pkg::ST_IDLE;
			baud_cnt <= 8'h00;
			edge_cnt <= '0;
			tx_buf <= '0;
			tx_shift <= '0;
			rx_shift <= '0;
			rx_data <= '0;
			reg_rdata <= '0;
			spi_sclk <= 1'b0;
			spi_mosi <= 1'b0;
			spi_sel_n <= 1'b1;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			mask <= next_mask;
			flags <= next_flags;
			state <= next_state;
			baud_cnt <= next_baud_cnt;
			edge_cnt <= next_edge_cnt;
			tx_buf <= next_tx_buf;
			tx_shift <= next_tx_shift;
			rx_shift <= next_rx_shift;
			rx_data <= next_rx_data;
			reg_rdata <= next_rdata;
			spi_sclk <= next_sclk;
			spi_mosi <= next_mosi;
			spi_sel_n <= ~next_flags.xfer_active_flag;
			irq <= next_irq;
		end
	end
endmodule
